// *** hw/icrl_pkg.sv ***
// Constants, field layouts and state codes of the instruction cache manager.
// Assumes a single core clock and 32-bit core register accesses.
package icrl_pkg;
    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    localparam int WAYS   = 4;
    localparam int LINES  = 128;
    localparam int LINE_W = 7;
    localparam int TAG_W  = 20;
    localparam int MEM_AW = 11;
    localparam int MEM_DW = 64;
    // ---------------------------------------------------------------
    // Test register selects
    // ---------------------------------------------------------------
    localparam logic [1:0] REG_CMD = 2'h0;
    localparam logic [1:0] REG_DLO = 2'h1;
    localparam logic [1:0] REG_DHI = 2'h2;
    localparam logic [31:0] CMD_RST  = 32'h00000000;
    localparam logic [31:0] DATA_RST = 32'h00000000;
    // ---------------------------------------------------------------
    // Test command fields
    // ---------------------------------------------------------------
    localparam int CMD_RW_BIT   = 1;
    localparam int CMD_ARR_BIT  = 2;
    localparam int CMD_DW_LSB   = 3;
    localparam int CMD_SET_LSB  = 5;
    localparam int CMD_WAY_LSB  = 10;
    localparam int CMD_SUBBANK_SELECT_FIELD_LSB = 12;
    // ---------------------------------------------------------------
    // Tag word layout in the lower test data register
    // ---------------------------------------------------------------
    localparam int TD_VALID_BIT = 0;
    localparam int TD_PRIO_BIT  = 1;
    localparam int TD_TAG_LSB   = 12;
    // ---------------------------------------------------------------
    // Fetch address fields
    // ---------------------------------------------------------------
    localparam int ADDR_DW_LSB   = 3;
    localparam int ADDR_SET_LSB  = 5;
    localparam int ADDR_TLO_LSB  = 10;
    localparam int ADDR_SUBBANK_SELECT_FIELD_LSB = 12;
    localparam int ADDR_THI_LSB  = 14;
    // ---------------------------------------------------------------
    // Test engine states
    // ---------------------------------------------------------------
    typedef enum logic [0:0]
    {
        TST_IDLE   = 1'b0,
        TST_RDWAIT = 1'b1
    } icrl_tst_type;
endpackage

// *** hw/icrl_line_ram.sv ***
// Instruction data array: one 64-bit double word per address.
// Assumes the caller arbitrates the single port; read data is registered.
module icrl_line_ram #(
    parameter int AW = icrl_pkg::MEM_AW,
    parameter int DW = icrl_pkg::MEM_DW
) (
    input  wire logic          core_clk,
    input  wire logic          en,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata_ff
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge core_clk)
    begin
        if (en && we)
        begin
            mem[addr] <= wdata;
        end
        if (en && !we)
        begin
            rdata_ff <= mem[addr];
        end
    end
endmodule // icrl_line_ram

// *** hw/icrl_top.sv ***
// Instruction cache tag state, victim choice, invalidation and test access.
// Assumes one miss outstanding at a time and a fill port fed by the line fetcher.
//
// Overview of operation
// - Single invalid way takes the new line
// - Several invalid: lowest numbered way wins
// - All valid: LRU with priority and locks
// - No DMA or data path into arrays
// - Fill stores page priority with the tag
// - High evicts low, low never evicts high
// - All high: low fetch served, not allocated
// - High: empty, then LRU low, then LRU high
// - Low: only empty or low ways, LRU
// - Demote bit turns all highs low
// - Four lock bits exclude ways from LRU
// - Locked lines leave by flush, test or configure bit low
// - All ways locked: no allocation at all
// - Flush clears valid of matching line only
// - Configure bit low invalidates every line
// - Test registers need supervisor or emulation
// - Command write starts one array access
// - Lower word bits 31..0, upper 63..32
// - Way and subbank fields pick 0 to 3
// - Direction 1 writes; array bit 1 data
// - Set field 32 sets, double word of four
// - Set from bits 9..5, tag compare
module icrl_top (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        fetch_req,
    input  wire logic [31:0] fetch_addr,
    input  wire logic        fetch_prio,
    input  wire logic        fetch_cacheable,
    output logic             fetch_ready,
    output logic             fetch_rsp,
    output logic             fetch_hit,
    output logic [63:0]      fetch_data,
    output logic             fetch_alloc,
    output logic [1:0]       fetch_way,
    input  wire logic        fill_wr,
    input  wire logic [1:0]  fill_dw,
    input  wire logic [63:0] fill_data,
    input  wire logic        fill_last,
    output logic             fill_ready,
    input  wire logic        flush_req,
    input  wire logic [31:0] flush_addr,
    input  wire logic        icache_configure_bit,
    input  wire logic        priority_demote_bit,
    input  wire logic [3:0]  way_lock_bits,
    input  wire logic        core_priv,
    input  wire logic        mmr_wr,
    input  wire logic        mmr_rd,
    input  wire logic [1:0]  mmr_sel,
    input  wire logic [31:0] mmr_wdata,
    output logic [31:0]      mmr_rdata,
    output logic             mmr_ack,
    output logic             mmr_reject
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [3:0][127:0][19:0] tag;
        logic [3:0][127:0]       valid;
        logic [3:0][127:0]       prio;
        logic [127:0][3:0][1:0]  age;
        logic [31:0]             cmd;
        logic [31:0]             dlo;
        logic [31:0]             dhi;
        logic [31:0]             rdata;
        icrl_pkg::icrl_tst_type  tst;
        logic                    ack;
        logic                    reject;
        logic                    rsp;
        logic                    hit;
        logic                    aok;
        logic [1:0]              vway;
        logic [6:0]              fline;
        logic [19:0]             ftag;
        logic                    fprio;
    } icrl_st_type;

    icrl_st_type st_ff;
    icrl_st_type nxt_st;

    logic        mem_en;
    logic        mem_we;
    logic [10:0] mem_addr;
    logic [63:0] mem_wdata;
    logic [63:0] mem_rdata;
    logic        tst_go;
    logic        tst_data;
    logic        fetch_fire;
    logic        lk_hit;
    logic [1:0]  lk_way;
    logic [6:0]  lk_line;
    logic [2:0]  lk_pick;
    logic [3:0]  lk_inv;
    logic [3:0]  lk_vld;
    logic [3:0]  lk_pri;
    logic [6:0]  fl_line;
    logic [6:0]  tl_line;
    logic [1:0]  tl_way;

    // ---------------------------------------------------------------
    // Decode helpers
    // ---------------------------------------------------------------
    // line index from fetch bits 13..12 (subbank) and 9..5 (set)
    function automatic logic [6:0] line_of(input logic [31:0] a);
        return {a[icrl_pkg::ADDR_SUBBANK_SELECT_FIELD_LSB+:2], a[icrl_pkg::ADDR_SET_LSB+:5]};
    endfunction

    function automatic logic [19:0] tag_of(input logic [31:0] a);
        return {a[31:icrl_pkg::ADDR_THI_LSB], a[icrl_pkg::ADDR_TLO_LSB+:2]};
    endfunction

    function automatic logic [1:0] first_way(input logic [3:0] v);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 3; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    // Returns {found, way}
    function automatic logic [2:0] pick(input logic [3:0] vld, input logic [3:0] pri,
                                        input logic [3:0][1:0] age, input logic [3:0] lck,
                                        input logic hi);
        logic [3:0] inv;
        logic [3:0] cand;
        logic [2:0] r;
        logic [1:0] best;
        inv  = ~vld & ~lck;
        cand = ~lck & ~pri;
        r    = 3'h0;
        best = 2'h0;
        // an invalid unlocked way is used first
        if (inv != 4'h0)
        begin
            r = {1'b1, first_way(inv)};
        end
        else
        begin
            // highs fall back to LRU among highs
            if (hi && cand == 4'h0)
            begin
                cand = ~lck;
            end
            // oldest candidate; lows see lows only
            for (int i = 0; i < 4; i++)
            begin
                if (cand[i] && (!r[2] || age[i] > best))
                begin
                    r    = {1'b1, 2'(i)};
                    best = age[i];
                end
            end
        end
        return r;
    endfunction

    // Ages stay a permutation of 0..3, so ties never occur
    function automatic logic [3:0][1:0] touch(input logic [3:0][1:0] a, input logic [1:0] w);
        logic [3:0][1:0] t;
        t = a;
        for (int i = 0; i < 4; i++)
        begin
            if (a[i] < a[w])
            begin
                t[i] = a[i] + 2'h1;
            end
        end
        t[w] = 2'h0;
        return t;
    endfunction

    // ---------------------------------------------------------------
    // Lookup and data array arbitration
    // ---------------------------------------------------------------
    assign lk_line     = line_of(fetch_addr);
    assign fl_line     = line_of(flush_addr);
    // way and subbank fields, set field
    assign tl_way      = mmr_wdata[icrl_pkg::CMD_WAY_LSB+:2];
    assign tl_line     = {mmr_wdata[icrl_pkg::CMD_SUBBANK_SELECT_FIELD_LSB+:2], mmr_wdata[icrl_pkg::CMD_SET_LSB+:5]};
    assign tst_go      = mmr_wr && core_priv && mmr_sel == icrl_pkg::REG_CMD;
    // array bit 1 targets data array
    assign tst_data    = tst_go && mmr_wdata[icrl_pkg::CMD_ARR_BIT];
    assign fill_ready  = !tst_data;
    assign fetch_ready = !tst_data && !fill_wr;
    assign fetch_fire  = fetch_req && fetch_ready;

    always_comb
    begin
        lk_hit = 1'b0;
        lk_way = 2'h0;
        lk_inv = 4'h0;
        lk_vld = 4'h0;
        lk_pri = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            lk_vld[i] = st_ff.valid[i][lk_line];
            lk_pri[i] = st_ff.prio[i][lk_line];
            lk_inv[i] = !lk_vld[i] && !way_lock_bits[i];
            // compare stored tags of valid lines
            if (st_ff.valid[i][lk_line] && st_ff.tag[i][lk_line] == tag_of(fetch_addr))
            begin
                lk_hit = 1'b1;
                lk_way = 2'(i);
            end
        end
        lk_pick = pick(lk_vld, lk_pri, st_ff.age[lk_line], way_lock_bits, fetch_prio);
    end

    // only test, fill and fetch reach the array
    always_comb
    begin
        mem_en    = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = {st_ff.vway, st_ff.fline, fill_dw};
        mem_wdata = fill_data;
        if (tst_data)
        begin
            mem_en    = 1'b1;
            mem_we    = mmr_wdata[icrl_pkg::CMD_RW_BIT];
            mem_addr  = {tl_way, tl_line, mmr_wdata[icrl_pkg::CMD_DW_LSB+:2]};
            mem_wdata = {st_ff.dhi, st_ff.dlo};
        end
        else if (fill_wr)
        begin
            mem_en = st_ff.aok;
            mem_we = 1'b1;
        end
        else if (fetch_req)
        begin
            mem_en   = 1'b1;
            mem_addr = {lk_way, lk_line, fetch_addr[icrl_pkg::ADDR_DW_LSB+:2]};
        end
    end

    icrl_line_ram #(
        .AW (icrl_pkg::MEM_AW),
        .DW (icrl_pkg::MEM_DW)
    ) u_ram (
        .core_clk (core_clk),
        .en       (mem_en),
        .we       (mem_we),
        .addr     (mem_addr),
        .wdata    (mem_wdata),
        .rdata_ff (mem_rdata)
    );

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_st        = st_ff;
        nxt_st.ack    = 1'b0;
        nxt_st.reject = 1'b0;
        nxt_st.rsp    = fetch_fire;
        // Fetch lookup, miss latches the victim
        if (fetch_fire)
        begin
            nxt_st.hit = lk_hit && icache_configure_bit;
            if (lk_hit && icache_configure_bit)
            begin
                nxt_st.age[lk_line] = touch(st_ff.age[lk_line], lk_way);
                nxt_st.aok          = 1'b0;
            end
            else
            begin
                // no way left means serve without allocating
                nxt_st.aok   = lk_pick[2] && fetch_cacheable && icache_configure_bit;
                nxt_st.vway  = lk_pick[1:0];
                nxt_st.fline = lk_line;
                nxt_st.ftag  = tag_of(fetch_addr);
                // page priority travels with the fill
                nxt_st.fprio = fetch_prio;
            end
        end
        // tag, valid and priority written at fill end
        if (fill_wr && fill_ready && fill_last && st_ff.aok)
        begin
            nxt_st.tag[st_ff.vway][st_ff.fline]   = st_ff.ftag;
            nxt_st.valid[st_ff.vway][st_ff.fline] = 1'b1;
            nxt_st.prio[st_ff.vway][st_ff.fline]  = st_ff.fprio;
            nxt_st.age[st_ff.fline] = touch(st_ff.age[st_ff.fline], st_ff.vway);
            nxt_st.aok = 1'b0;
        end
        // Register port; stale data read while a data read is in flight
        if ((mmr_wr || mmr_rd) && !core_priv)
        begin
            nxt_st.reject = 1'b1;
        end
        else if (mmr_wr || mmr_rd)
        begin
            nxt_st.ack = 1'b1;
            if (mmr_rd)
            begin
                nxt_st.rdata = (mmr_sel == icrl_pkg::REG_CMD) ? st_ff.cmd :
                               (mmr_sel == icrl_pkg::REG_DLO) ? st_ff.dlo :
                               (mmr_sel == icrl_pkg::REG_DHI) ? st_ff.dhi : 32'h00000000;
            end
            else if (mmr_sel == icrl_pkg::REG_DLO)
            begin
                nxt_st.dlo = mmr_wdata;
            end
            else if (mmr_sel == icrl_pkg::REG_DHI)
            begin
                nxt_st.dhi = mmr_wdata;
            end
            else if (mmr_sel == icrl_pkg::REG_CMD)
            begin
                nxt_st.cmd = mmr_wdata;
                if (tst_data && !mmr_wdata[icrl_pkg::CMD_RW_BIT])
                begin
                    nxt_st.tst = icrl_pkg::TST_RDWAIT;
                end
                // tag writes may evict locked lines
                else if (!tst_data && mmr_wdata[icrl_pkg::CMD_RW_BIT])
                begin
                    nxt_st.tag[tl_way][tl_line]   = st_ff.dlo[icrl_pkg::TD_TAG_LSB+:20];
                    nxt_st.valid[tl_way][tl_line] = st_ff.dlo[icrl_pkg::TD_VALID_BIT];
                    nxt_st.prio[tl_way][tl_line]  = st_ff.dlo[icrl_pkg::TD_PRIO_BIT];
                end
                else if (!tst_data)
                begin
                    // tag reads use the lower register only
                    nxt_st.dlo = 32'h00000000;
                    nxt_st.dlo[icrl_pkg::TD_TAG_LSB+:20] = st_ff.tag[tl_way][tl_line];
                    nxt_st.dlo[icrl_pkg::TD_VALID_BIT]   = st_ff.valid[tl_way][tl_line];
                    nxt_st.dlo[icrl_pkg::TD_PRIO_BIT]    = st_ff.prio[tl_way][tl_line];
                end
            end
        end
        case (st_ff.tst)
            icrl_pkg::TST_RDWAIT:
            begin
                nxt_st.dlo = mem_rdata[31:0];
                nxt_st.dhi = mem_rdata[63:32];
                nxt_st.tst = icrl_pkg::TST_IDLE;
            end
            default:
            begin
            end
        endcase
        // flush clears a matching valid line, no write-back
        if (flush_req)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (st_ff.tag[i][fl_line] == tag_of(flush_addr))
                begin
                    nxt_st.valid[i][fl_line] = 1'b0;
                end
            end
        end
        // cache off wipes all valid bits
        if (!icache_configure_bit)
        begin
            nxt_st.valid = '0;
            nxt_st.aok   = 1'b0;
        end
        // bulk demotion of every high line
        if (priority_demote_bit)
        begin
            nxt_st.prio = '0;
        end
        if (rst)
        begin
            nxt_st       = '0;
            nxt_st.cmd   = icrl_pkg::CMD_RST;
            nxt_st.dlo   = icrl_pkg::DATA_RST;
            nxt_st.dhi   = icrl_pkg::DATA_RST;
            for (int l = 0; l < icrl_pkg::LINES; l++)
            begin
                for (int i = 0; i < 4; i++)
                begin
                    nxt_st.age[l][i] = 2'(i);
                end
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        st_ff <= nxt_st;
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign fetch_rsp   = st_ff.rsp;
    assign fetch_hit   = st_ff.hit;
    assign fetch_data  = mem_rdata;
    assign fetch_alloc = st_ff.aok;
    assign fetch_way   = st_ff.vway;
    assign mmr_rdata   = st_ff.rdata;
    assign mmr_ack     = st_ff.ack;
    assign mmr_reject  = st_ff.reject;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_inv_first;
        @(posedge core_clk) disable iff (rst)
        fetch_fire && !lk_hit && lk_inv != 4'h0 && fetch_cacheable && icache_configure_bit
        |=> fetch_alloc && fetch_way == first_way($past(lk_inv));
    endproperty
    a_inv_first: assert property (p_inv_first) else $error("invalid way not taken first");

    property p_all_locked;
        @(posedge core_clk) disable iff (rst)
        fetch_fire && (&way_lock_bits) |=> !fetch_alloc;
    endproperty
    a_all_locked: assert property (p_all_locked) else $error("allocation with all ways locked");

    property p_low_keeps_high;
        @(posedge core_clk) disable iff (rst)
        fetch_fire && !fetch_prio && lk_pick[2] && lk_inv == 4'h0
        |-> !lk_pri[lk_pick[1:0]] && !way_lock_bits[lk_pick[1:0]];
    endproperty
    a_low_keeps_high: assert property (p_low_keeps_high) else $error("low line evicts high");

    property p_all_high;
        @(posedge core_clk) disable iff (rst)
        fetch_fire && !fetch_prio && lk_inv == 4'h0 && !lk_hit && lk_pri == 4'hf
        |=> fetch_rsp && !fetch_alloc;
    endproperty
    a_all_high: assert property (p_all_high) else $error("low fetch allocated over highs");

    property p_demote;
        @(posedge core_clk) disable iff (rst)
        priority_demote_bit |=> st_ff.prio == '0;
    endproperty
    a_demote: assert property (p_demote) else $error("high lines survive demotion");

    property p_cfg_off;
        @(posedge core_clk) disable iff (rst)
        !icache_configure_bit |=> st_ff.valid == '0 ##1 (!fetch_rsp || !fetch_hit);
    endproperty
    a_cfg_off: assert property (p_cfg_off) else $error("lines valid with cache off");

    property p_priv;
        @(posedge core_clk) disable iff (rst)
        (mmr_wr || mmr_rd) && !core_priv |=> mmr_reject && !mmr_ack && $stable(st_ff.cmd) && $stable(st_ff.dlo);
    endproperty
    a_priv: assert property (p_priv) else $error("test access without privilege");

    property p_flush;
        @(posedge core_clk) disable iff (rst)
        flush_req && !fill_wr && !tst_go && st_ff.valid[0][fl_line] && st_ff.tag[0][fl_line] == tag_of(flush_addr)
        |=> !st_ff.valid[0][$past(fl_line)];
    endproperty
    a_flush: assert property (p_flush) else $error("flushed line still valid");

    property p_tst_read;
        @(posedge core_clk) disable iff (rst)
        tst_data && !mmr_wdata[icrl_pkg::CMD_RW_BIT] |=> st_ff.tst == icrl_pkg::TST_RDWAIT
        ##1 st_ff.tst == icrl_pkg::TST_IDLE && st_ff.dhi == $past(mem_rdata[63:32]);
    endproperty
    a_tst_read: assert property (p_tst_read) else $error("test data read not landed");

    property p_tag_wr;
        @(posedge core_clk) disable iff (rst)
        tst_go && !tst_data && mmr_wdata[icrl_pkg::CMD_RW_BIT] && !flush_req && icache_configure_bit
        |=> st_ff.valid[$past(tl_way)][$past(tl_line)] == $past(st_ff.dlo[icrl_pkg::TD_VALID_BIT]);
    endproperty
    a_tag_wr: assert property (p_tag_wr) else $error("tag write lost");
endmodule // icrl_top

// *** test/icrl_core_model.sv ***
// Core fetch side model: fetch lookups and line fills.
// Assumes icrl_top samples on the rising core_clk edge.
module icrl_core_model (
    input  wire logic   core_clk,
    output logic        fetch_req,
    output logic [31:0] fetch_addr,
    output logic        fetch_prio,
    output logic        fetch_cacheable,
    output logic        fill_wr,
    output logic [1:0]  fill_dw,
    output logic [63:0] fill_data,
    output logic        fill_last
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {fetch_req, fetch_prio, fill_wr, fill_last} = 4'h0;
        fetch_cacheable = 1'h1;
        fill_dw = 2'h0;
        fetch_addr = '0;
        fill_data = '0;
    end
    // Released address and fill data show the inverse; fetch_prio and fill_dw keep their last value
    task automatic fetch(input logic [31:0] a, input logic p);
        @(negedge core_clk);
        fetch_req = 1'h1;
        fetch_addr = a;
        fetch_prio = p;
        @(negedge core_clk);
        fetch_req = 1'h0;
        fetch_addr = ~a;
    endtask
    task automatic fill(input logic [63:0] d);
        for (int i = 0; i < 4; i++)
        begin
            @(negedge core_clk);
            fill_wr = 1'h1;
            fill_dw = 2'(i);
            fill_data = d + 64'(i);
            fill_last = (i == 3);
        end
        @(negedge core_clk);
        {fill_wr, fill_last} = 2'h0;
        fill_data = ~fill_data;
    endtask
endmodule // icrl_core_model

// *** test/icache_replace_lock_test_test.sv ***
// Bench for icrl_top: test port accesses, fetches and fills.
// Assumes icrl_core_model drives the fetch and fill side.
module icache_replace_lock_test_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst, flush_req, icache_configure_bit, priority_demote_bit, core_priv, mmr_wr, mmr_rd;
    logic        fetch_req, fetch_prio, fetch_cacheable, fill_wr, fill_last, fetch_ready, fetch_rsp, fetch_hit;
    logic        fetch_alloc, fill_ready, mmr_ack, mmr_reject;
    logic [1:0]  mmr_sel, fill_dw, fetch_way;
    logic [3:0]  way_lock_bits;
    logic [31:0] fetch_addr, flush_addr, mmr_wdata, mmr_rdata;
    logic [63:0] fill_data, fetch_data;
    int          bad_count = 0, n_tests = 0, cyc = 0;
    logic [3:0]  vm [4] = '{4'h7, 4'hc, 4'h3, 4'hd};
    logic [1:0]  ew [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
    icrl_top DUT (.core_clk, .rst, .fetch_req, .fetch_addr, .fetch_prio, .fetch_cacheable, .fetch_ready,
        .fetch_rsp, .fetch_hit, .fetch_data, .fetch_alloc, .fetch_way, .fill_wr, .fill_dw, .fill_data,
        .fill_last, .fill_ready, .flush_req, .flush_addr, .icache_configure_bit, .priority_demote_bit,
        .way_lock_bits, .core_priv, .mmr_wr, .mmr_rd, .mmr_sel, .mmr_wdata, .mmr_rdata, .mmr_ack, .mmr_reject);
    icrl_core_model core (.core_clk, .fetch_req, .fetch_addr, .fetch_prio, .fetch_cacheable, .fill_wr,
        .fill_dw, .fill_data, .fill_last);
    initial
    begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            test_done;
        end
    end
    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        n_tests++;
        if (s !== e)
            $display("[ERR] %s exp %h got %h", n, e, s);
        if (s !== e)
            bad_count++;
    endtask
    task automatic mmr(input logic w, input logic [1:0] sel, input logic [31:0] d);
        @(negedge core_clk);
        {mmr_wr, mmr_rd, mmr_sel, mmr_wdata} = {w, !w, sel, d};
        #1;
        if (w && sel == icrl_pkg::REG_CMD)
            chk("ready", {fetch_ready, fill_ready}, {2{!d[icrl_pkg::CMD_ARR_BIT]}});
        @(negedge core_clk);
        {mmr_wr, mmr_rd, mmr_wdata} = {2'h0, ~d};
    endtask
    function automatic logic [31:0] cmd(input logic [1:0] w, input logic [4:0] s, input logic [2:0] dar);
        return {18'h0, 2'h0, w, s, 1'h0, dar, 1'h0};
    endfunction
    function automatic logic [31:0] fa(input logic [19:0] t, input logic [4:0] s);
        return {t[19:2], 2'h0, t[1:0], s, 5'h0};
    endfunction
    // Test port: data first, then command
    task automatic tagw(input logic [1:0] w, input logic [4:0] s, input logic [19:0] t, input logic p);
        mmr(1'h1, icrl_pkg::REG_DLO, {t, 10'h0, p, 1'h1});
        mmr(1'h1, icrl_pkg::REG_CMD, cmd(w, s, 3'h1));
    endtask
    task automatic pulse(input int k);
        @(negedge core_clk);
        {flush_req, icache_configure_bit, priority_demote_bit} = (k == 0) ? 3'h6 : (k == 1) ? 3'h0 : 3'h3;
        @(negedge core_clk);
        {flush_req, icache_configure_bit, priority_demote_bit} = 3'h2;
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        {rst, icache_configure_bit, core_priv, flush_req, priority_demote_bit, mmr_wr, mmr_rd} = 7'h70;
        {mmr_sel, way_lock_bits, mmr_wdata, flush_addr} = '0;
        repeat (5) @(negedge core_clk);
        rst = 1'h0;
        mmr(1'h0, icrl_pkg::REG_CMD, '0);
        chk("cmd_rst", mmr_rdata, 32'h0);
        core_priv = 1'h0;
        mmr(1'h1, icrl_pkg::REG_DLO, 32'h5a5a5a5a);
        chk("reject", {mmr_reject, mmr_ack}, 2'h2);
        core_priv = 1'h1;
        mmr(1'h0, icrl_pkg::REG_DLO, '0);
        chk("no_write", mmr_rdata, 32'h0);
        mmr(1'h1, icrl_pkg::REG_DLO, 32'h12345678);
        mmr(1'h1, icrl_pkg::REG_DHI, 32'h9abcdef0);
        mmr(1'h1, icrl_pkg::REG_CMD, cmd(2'h2, 5'h13, 3'h7));
        mmr(1'h1, icrl_pkg::REG_DLO, '0);
        mmr(1'h1, icrl_pkg::REG_DHI, '0);
        mmr(1'h1, icrl_pkg::REG_CMD, cmd(2'h2, 5'h13, 3'h6));
        mmr(1'h0, icrl_pkg::REG_CMD, '0);
        chk("cmd", mmr_rdata, cmd(2'h2, 5'h13, 3'h6));
        mmr(1'h0, icrl_pkg::REG_DLO, '0);
        chk("dlo", mmr_rdata, 32'h12345678);
        mmr(1'h0, icrl_pkg::REG_DHI, '0);
        chk("dhi", mmr_rdata, 32'h9abcdef0);
        for (int k = 0; k < 4; k++)
        begin
            for (int w = 0; w < 4; w++)
                if (vm[k][w])
                    tagw(2'(w), 5'(k), 20'habc, 1'h0);
            core.fetch(fa(20'hdef, 5'(k)), 1'h0);
            chk("victim", {fetch_rsp, fetch_hit, fetch_alloc, fetch_way}, {3'h5, ew[k]});
        end
        core.fetch(fa(20'habc, 5'h0), 1'h0);
        chk("hit", {fetch_rsp, fetch_hit}, 2'h3);
        for (int w = 0; w < 4; w++)
            tagw(2'(w), 5'h8, 20'habc, 1'h1);
        for (int w = 0; w < 4; w++)
            tagw(2'(w), 5'h9, 20'habc, !w[0]);
        core.fetch(fa(20'hdef, 5'h9), 1'h0);
        chk("low_way", {fetch_alloc, fetch_way[0]}, 2'h3);
        core.fetch(fa(20'hdef, 5'h9), 1'h1);
        chk("high_way", {fetch_alloc, fetch_way[0]}, 2'h3);
        core.fetch(fa(20'hdef, 5'h8), 1'h0);
        chk("all_high", {fetch_rsp, fetch_hit, fetch_alloc}, 3'h4);
        pulse(2);
        core.fetch(fa(20'hdef, 5'h8), 1'h0);
        chk("demoted", fetch_alloc, 1'h1);
        way_lock_bits = 4'h1;
        core.fetch(fa(20'hdef, 5'h4), 1'h0);
        chk("lock0", {fetch_alloc, fetch_way}, 3'h5);
        way_lock_bits = 4'hf;
        core.fetch(fa(20'hdef, 5'h5), 1'h0);
        chk("lock_all", fetch_alloc, 1'h0);
        way_lock_bits = 4'h0;
        core.fetch(fa(20'h1234, 5'h6), 1'h1);
        core.fill(64'h0123456789abcdef);
        core.fetch(fa(20'h1234, 5'h6), 1'h1);
        chk("fill_hit", {fetch_hit, fetch_data}, {1'h1, 64'h0123456789abcdef});
        mmr(1'h1, icrl_pkg::REG_CMD, cmd(2'h0, 5'h6, 3'h0));
        mmr(1'h0, icrl_pkg::REG_DLO, '0);
        chk("prio_tag", mmr_rdata, {20'h1234, 12'h3});
        flush_addr = fa(20'h1234, 5'h6);
        pulse(0);
        core.fetch(fa(20'h1234, 5'h6), 1'h1);
        chk("flushed", fetch_hit, 1'h0);
        core.fetch(fa(20'habc, 5'h0), 1'h0);
        chk("kept", fetch_hit, 1'h1);
        pulse(1);
        core.fetch(fa(20'habc, 5'h0), 1'h0);
        chk("cfg_off", fetch_hit, 1'h0);
        test_done;
    end
endmodule // icache_replace_lock_test_test
